// *** hdl/bit_sync3.sv ***
// Three-stage synchroniser with agreement filter for one bit.
// Assumes din is asynchronous to clk; dout changes once stages two and three agree.
`timescale 1ns/1ps
`default_nettype none
module bit_sync3 (
   input  wire logic clk,
   input  wire logic din,
   output logic      dout
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic out;
   } sync_s;

   sync_s q;
   sync_s next_q;

   // Stage one feeds stage two only; the filtered level follows agreement.
   always_comb begin
      next_q     = q;
      next_q.s1  = din;
      next_q.s2  = q.s1;
      next_q.s3  = q.s2;
      if (q.s2 == q.s3) begin
         next_q.out = q.s3;
      end
   end

   // State register.
   always_ff @(posedge clk) begin
      q <= next_q;
   end

   assign dout = q.out;

endmodule : bit_sync3
`default_nettype wire

// *** hdl/ioexp_pkg.sv ***
// Constants shared by the I/O expander target engine and its register core.
// Assumes an I2C bus with external pull-ups and a 4-bit port.
package ioexp_pkg;

   // Bus addresses and the one code that the General Call accepts.
   localparam logic [6:0] DEFAULT_DEV_ADDR = 7'h41;
   localparam logic [6:0] GEN_CALL_ADDR    = 7'h00;
   localparam logic [7:0] SOFT_RESET_CODE  = 8'h06;

   // Selector codes of the internal registers.
   localparam logic [7:0] SEL_INPUT     = 8'h00;
   localparam logic [7:0] SEL_OUTPUT    = 8'h01;
   localparam logic [7:0] SEL_POLARITY  = 8'h02;
   localparam logic [7:0] SEL_DIRECTION = 8'h03;
   localparam logic [7:0] SEL_SPECIAL   = 8'h50;

   // Power-on values; unused bits always read as these values.
   localparam logic [7:0] INPUT_RESET     = 8'hF0;
   localparam logic [7:0] OUTPUT_RESET    = 8'hFF;
   localparam logic [7:0] POLARITY_RESET  = 8'h00;
   localparam logic [7:0] DIRECTION_RESET = 8'hFF;
   localparam logic [7:0] SPECIAL_RESET   = 8'h00;
   localparam logic [7:0] SELECTOR_RESET  = 8'h00;
   localparam logic [7:0] UNMAPPED_READ   = 8'h00;

   // Writable bits of each register.
   localparam logic [7:0] PORT_MASK    = 8'h0F;
   localparam logic [7:0] SPECIAL_MASK = 8'hC0;

   // Field positions in the special function register.
   localparam int SFR_INT_BIT  = 7;
   localparam int SFR_PUDIS_BIT = 6;

   // Position of each register inside the snapshot word.
   localparam int SNAP_INPUT     = 0;
   localparam int SNAP_OUTPUT    = 8;
   localparam int SNAP_POLARITY  = 16;
   localparam int SNAP_DIRECTION = 24;
   localparam int SNAP_SPECIAL   = 32;
   localparam int SNAP_W         = 40;

   // Keeps the writable bits of data and the fixed value in the others.
   function automatic logic [7:0] mergeWrite(input logic [7:0] data,
                                             input logic [7:0] fixed,
                                             input logic [7:0] mask);
      mergeWrite = (data & mask) | (fixed & ~mask);
   endfunction : mergeWrite

endpackage : ioexp_pkg

// *** hdl/ioexp_target.sv ***
// I2C target engine and register core of a 4-bit I/O expander.
// Assumes busSampleClk runs free and much faster than SCL; clk runs the register core.
// Operation
// - Write: START, address with write bit, ack, then selector byte.
// - Selector byte is acknowledged; data bytes follow; STOP ends the write.
// - Read: selector write, repeated START, address with read bit, data returned.
// - Selector byte chooses the register that later data bytes reach.
// - No auto-increment; every read byte returns the same register.
// - After repeated START the register selected at that moment is presented.
// - Register data is captured on the rising clock edge of the acknowledge bit.
// - STOP may end a transfer anywhere; data of last acknowledge stays.
// - General Call address with write bit is acknowledged.
// - General Call address with read bit is not acknowledged.
// - Only a 0x06 byte after General Call is acknowledged and arms reset.
// - Extra bytes after General Call are not acknowledged; message discarded.
// - Reset happens only at STOP; repeated START cancels it.
// - Software reset restores all registers; all pins become inputs.
// - Device answers its one fixed 7-bit address given by variant.
// - Address byte LSB one means read, zero means write.
// - Selectors 0x00,0x01,0x02,0x03,0x50 map to input,output,polarity,direction,special.
// - Last selector is kept until a new one is written or a software reset clears it.
// - Writes to the input level register change nothing.
`timescale 1ns/1ps
`default_nettype none
module ioexp_target #(
   parameter logic [6:0] DEV_ADDR = ioexp_pkg::DEFAULT_DEV_ADDR
) (
   input  wire logic       clk,
   input  wire logic       nrst,
   input  wire logic       busSampleClk,
   input  wire logic       sclIn,
   input  wire logic       sdaIn,
   output logic            sdaOut,
   output logic            sdaOe,
   input  wire logic [3:0] portIn,
   output logic      [3:0] portOut,
   output logic      [3:0] portOe,
   output logic      [3:0] pullupEn,
   output logic            fourthPinIntMode
);

   typedef enum logic [2:0] {
      LS_IDLE, LS_RECV, LS_ACK, LS_TX, LS_MACK, LS_IGNORE
   } linkState_e;

   typedef enum logic [2:0] {
      BK_ADDR, BK_SEL, BK_DATA, BK_GC, BK_GCX
   } byteKind_e;

   typedef struct packed {
      linkState_e               st;
      byteKind_e                kind;
      logic                     ackPhase;
      logic                     ackCont;
      logic                     isRead;
      logic                     gcAddr;
      logic                     gcOk;
      logic [2:0]               bitCnt;
      logic [7:0]               rxShift;
      logic [7:0]               txShift;
      logic [7:0]               selector;
      logic                     sdaOe;
      logic                     sdaLow;
      logic                     sclP;
      logic                     sdaP;
      logic                     wrTog;
      logic [7:0]               wrSel;
      logic [7:0]               wrData;
      logic                     rstTog;
      logic                     ackTog;
      logic [ioexp_pkg::SNAP_W-1:0] mirror;
   } link_s;

   typedef struct packed {
      logic [7:0]               outReg;
      logic [7:0]               polReg;
      logic [7:0]               dirReg;
      logic [7:0]               sfrReg;
      logic                     wrSeen;
      logic                     rstSeen;
      logic                     reqTog;
      logic [ioexp_pkg::SNAP_W-1:0] snapshot;
      logic [3:0]               portOut;
      logic [3:0]               portOe;
      logic [3:0]               pullupEn;
      logic                     intMode;
   } core_s;

   link_s l;
   link_s next_l;
   core_s c;
   core_s next_c;

   // Picks one register out of a snapshot word by its selector.
   function automatic logic [7:0] regAt(input logic [ioexp_pkg::SNAP_W-1:0] m,
                                        input logic [7:0] sel);
      case (sel)
         ioexp_pkg::SEL_INPUT:     regAt = m[ioexp_pkg::SNAP_INPUT +: 8];
         ioexp_pkg::SEL_OUTPUT:    regAt = m[ioexp_pkg::SNAP_OUTPUT +: 8];
         ioexp_pkg::SEL_POLARITY:  regAt = m[ioexp_pkg::SNAP_POLARITY +: 8];
         ioexp_pkg::SEL_DIRECTION: regAt = m[ioexp_pkg::SNAP_DIRECTION +: 8];
         ioexp_pkg::SEL_SPECIAL:   regAt = m[ioexp_pkg::SNAP_SPECIAL +: 8];
         default:                  regAt = ioexp_pkg::UNMAPPED_READ;
      endcase
   endfunction : regAt

   // Crossings into the link domain: bus pins, snapshot request, reset.
   logic [2:0] linkRaw;
   logic [2:0] linkSync;
   assign linkRaw = {nrst, c.reqTog, sclIn & 1'b1};
   logic sdaF;
   bit_sync3 u_sdaSync (
      .clk  (busSampleClk),
      .din  (sdaIn),
      .dout (sdaF)
   );
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_linkSync
         bit_sync3 u_sync (
            .clk  (busSampleClk),
            .din  (linkRaw[gi]),
            .dout (linkSync[gi])
         );
      end
   endgenerate

   logic sclF;
   logic reqTogL;
   logic linkRstN;
   assign sclF     = linkSync[0];
   assign reqTogL  = linkSync[1];
   assign linkRstN = linkSync[2];

   // Crossings into the core domain: pins, write event, reset event, snapshot ack.
   logic [6:0] coreRaw;
   logic [6:0] coreSync;
   assign coreRaw = {l.ackTog, l.rstTog, l.wrTog, portIn};
   generate
      for (gi = 0; gi < 7; gi++) begin : g_coreSync
         bit_sync3 u_sync (
            .clk  (clk),
            .din  (coreRaw[gi]),
            .dout (coreSync[gi])
         );
      end
   endgenerate

   // Bus condition and edge detection from filtered line levels.
   logic sclRise;
   logic sclFall;
   logic startCond;
   logic stopCond;
   logic [7:0] byteVal;
   assign sclRise   = ~l.sclP & sclF;
   assign sclFall   = l.sclP & ~sclF;
   assign startCond = sclF & l.sclP & l.sdaP & ~sdaF;
   assign stopCond  = sclF & l.sclP & ~l.sdaP & sdaF;
   assign byteVal   = {l.rxShift[6:0], sdaF};

   // Link protocol engine: receive, acknowledge, transmit, General Call.
   always_comb begin
      next_l      = l;
      next_l.sclP = sclF;
      next_l.sdaP = sdaF;
      // Fresh register contents arrive by request/acknowledge toggles.
      if (reqTogL != l.ackTog) begin
         next_l.mirror = c.snapshot;
         next_l.ackTog = reqTogL;
      end
      case (l.st)
         LS_IDLE, LS_IGNORE: begin
            next_l.sdaOe = 1'b0;
         end
         LS_RECV: begin
            if (sclRise) begin
               next_l.rxShift = byteVal;
               next_l.bitCnt  = l.bitCnt + 3'h1;
               if (l.bitCnt == 3'h7) begin
                  next_l.ackPhase = 1'b0;
                  case (l.kind)
                     BK_ADDR: begin
                        next_l.isRead = byteVal[0];
                        next_l.gcAddr = 1'b0;
                        if (byteVal[7:1] == DEV_ADDR) begin
                           next_l.st = LS_ACK;
                        end else if (byteVal[7:1] == ioexp_pkg::GEN_CALL_ADDR &&
                                     !byteVal[0]) begin
                           next_l.st     = LS_ACK;
                           next_l.gcAddr = 1'b1;
                        end else begin
                           next_l.st = LS_IGNORE;
                        end
                     end
                     BK_SEL, BK_DATA: begin
                        next_l.st = LS_ACK;
                     end
                     BK_GC: begin
                        if (byteVal == ioexp_pkg::SOFT_RESET_CODE) begin
                           next_l.st = LS_ACK;
                        end else begin
                           next_l.st = LS_IGNORE;
                        end
                     end
                     default: begin
                        next_l.gcOk = 1'b0;
                        next_l.st   = LS_IGNORE;
                     end
                  endcase
               end
            end
         end
         LS_ACK: begin
            if (sclFall && !l.ackPhase) begin
               next_l.sdaOe    = 1'b1;
               next_l.ackPhase = 1'b1;
            end else if (sclRise && l.ackPhase) begin
               // Work of the byte is committed at the acknowledge clock rise.
               case (l.kind)
                  BK_ADDR: begin
                     if (l.isRead && !l.gcAddr) begin
                        next_l.txShift = regAt(l.mirror, l.selector);
                     end
                  end
                  BK_SEL: begin
                     next_l.selector = l.rxShift;
                  end
                  BK_DATA: begin
                     next_l.wrSel  = l.selector;
                     next_l.wrData = l.rxShift;
                     next_l.wrTog  = ~l.wrTog;
                  end
                  BK_GC: begin
                     next_l.gcOk = 1'b1;
                  end
                  default: begin
                     next_l.gcOk = 1'b0;
                  end
               endcase
            end else if (sclFall && l.ackPhase) begin
               next_l.ackPhase = 1'b0;
               next_l.bitCnt   = 3'h0;
               next_l.sdaOe    = 1'b0;
               next_l.st       = LS_RECV;
               case (l.kind)
                  BK_ADDR: begin
                     if (l.gcAddr) begin
                        next_l.kind = BK_GC;
                     end else if (l.isRead) begin
                        next_l.st    = LS_TX;
                        next_l.sdaOe = ~l.txShift[7];
                     end else begin
                        next_l.kind = BK_SEL;
                     end
                  end
                  BK_SEL, BK_DATA: begin
                     next_l.kind = BK_DATA;
                  end
                  default: begin
                     next_l.kind = BK_GCX;
                  end
               endcase
            end
         end
         LS_TX: begin
            if (sclRise) begin
               if (l.bitCnt == 3'h7) begin
                  next_l.st       = LS_MACK;
                  next_l.bitCnt   = 3'h0;
                  next_l.ackPhase = 1'b0;
               end else begin
                  next_l.bitCnt = l.bitCnt + 3'h1;
               end
            end else if (sclFall) begin
               next_l.txShift = {l.txShift[6:0], 1'b0};
               next_l.sdaOe   = ~l.txShift[6];
            end
         end
         LS_MACK: begin
            if (sclFall && !l.ackPhase) begin
               next_l.sdaOe    = 1'b0;
               next_l.ackPhase = 1'b1;
            end else if (sclRise && l.ackPhase) begin
               next_l.ackCont = ~sdaF;
               if (!sdaF) begin
                  next_l.txShift = regAt(l.mirror, l.selector);
               end
            end else if (sclFall && l.ackPhase) begin
               next_l.ackPhase = 1'b0;
               if (l.ackCont) begin
                  next_l.st    = LS_TX;
                  next_l.sdaOe = ~l.txShift[7];
               end else begin
                  next_l.st = LS_IGNORE;
               end
            end
         end
         default: begin
            next_l.st = LS_IDLE;
         end
      endcase
      // Bus conditions override every state.
      if (startCond) begin
         next_l.st       = LS_RECV;
         next_l.kind     = BK_ADDR;
         next_l.bitCnt   = 3'h0;
         next_l.ackPhase = 1'b0;
         next_l.sdaOe    = 1'b0;
         next_l.gcOk     = 1'b0;
      end else if (stopCond) begin
         next_l.st    = LS_IDLE;
         next_l.sdaOe = 1'b0;
         next_l.gcOk  = 1'b0;
         if (l.gcOk) begin
            next_l.rstTog   = ~l.rstTog;
            next_l.selector = ioexp_pkg::SELECTOR_RESET;
         end
      end
      if (!linkRstN) begin
         next_l          = '0;
         next_l.st       = LS_IDLE;
         next_l.kind     = BK_ADDR;
         next_l.sclP     = 1'b1;
         next_l.sdaP     = 1'b1;
         next_l.selector = ioexp_pkg::SELECTOR_RESET;
         // Handshake toggles restart from zero, so no unknown value survives power-up.
      end
   end

   // Link domain state register.
   always_ff @(posedge busSampleClk) begin
      l <= next_l;
   end

   // Register core: applies writes, software reset and publishes snapshots.
   always_comb begin
      logic [3:0] inLevel;
      logic [7:0] inReg;
      inLevel = coreSync[3:0] ^ (c.polReg[3:0] & c.dirReg[3:0]);
      inReg   = ioexp_pkg::mergeWrite({4'h0, inLevel}, ioexp_pkg::INPUT_RESET,
                                      ioexp_pkg::PORT_MASK);
      next_c  = c;
      // A write event is taken once per toggle of the link write flag.
      if (coreSync[4] != c.wrSeen) begin
         next_c.wrSeen = coreSync[4];
         case (l.wrSel)
            ioexp_pkg::SEL_OUTPUT: begin
               next_c.outReg = ioexp_pkg::mergeWrite(l.wrData, ioexp_pkg::OUTPUT_RESET,
                                                     ioexp_pkg::PORT_MASK);
            end
            ioexp_pkg::SEL_POLARITY: begin
               next_c.polReg = ioexp_pkg::mergeWrite(l.wrData, ioexp_pkg::POLARITY_RESET,
                                                     ioexp_pkg::PORT_MASK);
            end
            ioexp_pkg::SEL_DIRECTION: begin
               next_c.dirReg = ioexp_pkg::mergeWrite(l.wrData, ioexp_pkg::DIRECTION_RESET,
                                                     ioexp_pkg::PORT_MASK);
            end
            ioexp_pkg::SEL_SPECIAL: begin
               next_c.sfrReg = ioexp_pkg::mergeWrite(l.wrData, ioexp_pkg::SPECIAL_RESET,
                                                     ioexp_pkg::SPECIAL_MASK);
            end
            default: begin
               next_c.outReg = c.outReg;
            end
         endcase
      end
      // Software reset wins over a write seen in the same cycle.
      if (coreSync[5] != c.rstSeen) begin
         next_c.rstSeen = coreSync[5];
         next_c.outReg  = ioexp_pkg::OUTPUT_RESET;
         next_c.polReg  = ioexp_pkg::POLARITY_RESET;
         next_c.dirReg  = ioexp_pkg::DIRECTION_RESET;
         next_c.sfrReg  = ioexp_pkg::SPECIAL_RESET;
      end
      // A new snapshot goes out once the previous one has been taken.
      if (coreSync[6] == c.reqTog) begin
         next_c.snapshot[ioexp_pkg::SNAP_INPUT +: 8]     = inReg;
         next_c.snapshot[ioexp_pkg::SNAP_OUTPUT +: 8]    = c.outReg;
         next_c.snapshot[ioexp_pkg::SNAP_POLARITY +: 8]  = c.polReg;
         next_c.snapshot[ioexp_pkg::SNAP_DIRECTION +: 8] = c.dirReg;
         next_c.snapshot[ioexp_pkg::SNAP_SPECIAL +: 8]   = c.sfrReg;
         next_c.reqTog = ~c.reqTog;
      end
      // Pin controls follow the next register values so outputs stay registered.
      next_c.portOut  = next_c.outReg[3:0];
      next_c.portOe   = ~next_c.dirReg[3:0];
      next_c.pullupEn = next_c.dirReg[3:0] &
                        {4{~next_c.sfrReg[ioexp_pkg::SFR_PUDIS_BIT]}};
      next_c.intMode  = next_c.sfrReg[ioexp_pkg::SFR_INT_BIT];
      if (!nrst) begin
         next_c          = '0;
         next_c.outReg   = ioexp_pkg::OUTPUT_RESET;
         next_c.polReg   = ioexp_pkg::POLARITY_RESET;
         next_c.dirReg   = ioexp_pkg::DIRECTION_RESET;
         next_c.sfrReg   = ioexp_pkg::SPECIAL_RESET;
         // Seen flags clear to zero to match the link toggles, which also restart at zero.
         next_c.portOut  = ioexp_pkg::OUTPUT_RESET[3:0];
         next_c.pullupEn = 4'hF;
      end
   end

   // Core domain state register.
   always_ff @(posedge clk) begin
      c <= next_c;
   end

   // Top outputs come straight from state flip-flops.
   assign sdaOut           = l.sdaLow;
   assign sdaOe            = l.sdaOe;
   assign portOut          = c.portOut;
   assign portOe           = c.portOe;
   assign pullupEn         = c.pullupEn;
   assign fourthPinIntMode = c.intMode;

endmodule : ioexp_target
`default_nettype wire

// *** verif/i2c_ctrl_model.sv ***
// Behavioural I2C bus controller facing the target.
// Assumes pull-ups on SCL and SDA; sdaOe high means the target pulls SDA.
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
   input  wire logic clk,
   input  wire logic sdaOe,
   output logic      sclIn,
   output logic      sdaIn
);
   logic sdaRel;
   // Wired SDA: released level is the pull-up.
   assign sdaIn = sdaRel & ~sdaOe;
   // Both lines stand released while idle.
   initial begin
      sclIn = 1'b1;
      sdaRel = 1'b1;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask : wt
   // One bit: SDA set mid SCL low, sampled late in SCL high.
   task automatic bitIo(input logic b, output logic s);
      sclIn <= 1'b0;
      wt(3);
      sdaRel <= b;
      wt(3);
      sclIn <= 1'b1;
      wt(6);
      s = sdaIn;
   endtask : bitIo
   task automatic start();
      sdaRel <= 1'b0;
      wt(6);
   endtask : start
   task automatic rstart();
      sclIn <= 1'b0;
      wt(3);
      sdaRel <= 1'b1;
      wt(3);
      sclIn <= 1'b1;
      wt(3);
      sdaRel <= 1'b0;
      wt(3);
   endtask : rstart
   task automatic stop();
      sclIn <= 1'b0;
      wt(3);
      sdaRel <= 1'b0;
      wt(3);
      sclIn <= 1'b1;
      wt(3);
      sdaRel <= 1'b1;
      wt(6);
   endtask : stop
   task automatic sendByte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bitIo(d[i], s);
      bitIo(1'b1, s);
      ack = ~s;
   endtask : sendByte
   task automatic recvByte(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) bitIo(1'b1, d[i]);
      bitIo(~more, s);
   endtask : recvByte
endmodule : i2c_ctrl_model
`default_nettype wire

// *** verif/i2c_target_register_access_tb_top.sv ***
// Self-checking bench for the I/O expander target over its I2C link.
// Assumes the controller model drives SCL and SDA.
`timescale 1ns/1ps
`default_nettype none
module i2c_target_register_access_tb_top;
   logic       clk, busSampleClk, nrst, sclIn, sdaIn, sdaOut, sdaOe, fourthPinIntMode;
   logic [3:0] portIn, portOut, portOe, pullupEn;
   int         fails = 0;
   int         samples_checked = 0;
   int         cycles = 0;
   // Core clock at 20 MHz and an unrelated 15 ns sampling clock.
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial begin
      busSampleClk = 1'b0;
      #3.3;
      forever #7.5 busSampleClk = ~busSampleClk;
   end
   ioexp_target dut (.clk(clk), .nrst(nrst), .busSampleClk(busSampleClk), .sclIn(sclIn),
      .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .portIn(portIn), .portOut(portOut),
      .portOe(portOe), .pullupEn(pullupEn), .fourthPinIntMode(fourthPinIntMode));
   i2c_ctrl_model bus (.clk(clk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
   task automatic test_done();
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : test_done
   task automatic chkB(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask : chkB
   task automatic chk1(input string n, input logic e, input logic g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("unexpected %s: expected %b seen %b", n, e, g);
      end
   endtask : chk1
   task automatic ack(input logic [7:0] d, input logic e);
      logic a;
      bus.sendByte(d, a);
      chk1("ack", e, a);
   endtask : ack
   task automatic pre(input logic [7:0] s);
      bus.start();
      ack(8'h82, 1'b1);
      ack(s, 1'b1);
   endtask : pre
   task automatic wr(input logic [7:0] s, input logic [7:0] d);
      pre(s);
      ack(d, 1'b1);
      bus.stop();
   endtask : wr
   task automatic rd(input logic [7:0] s, input int n, input logic [7:0] e);
      logic [7:0] v;
      pre(s);
      bus.rstart();
      ack(8'h83, 1'b1);
      for (int i = 0; i < n; i++) begin
         bus.recvByte(i < n - 1, v);
         chkB("readData", e, v);
      end
      bus.stop();
   endtask : rd
   task automatic t_defaults();
      rd(8'h01, 1, 8'hFF);
      rd(8'h02, 1, 8'h00);
      rd(8'h03, 1, 8'hFF);
      rd(8'h50, 1, 8'h00);
      rd(8'h04, 1, 8'h00);
      chkB("portOe", 8'h00, {4'h0, portOe});
   endtask : t_defaults
   task automatic t_write_read();
      wr(8'h01, 8'h05);
      wr(8'h03, 8'h0A);
      chkB("portOut", 8'h05, {4'h0, portOut});
      chkB("portOe", 8'h05, {4'h0, portOe});
      rd(8'h01, 3, 8'hF5);
      wr(8'h02, 8'h0F);
      rd(8'h00, 2, 8'hFC);
      portIn <= 4'h9;
      rd(8'h00, 1, 8'hF3);
      wr(8'h00, 8'h00);
      rd(8'h01, 1, 8'hF5);
      wr(8'h50, 8'hC0);
      chk1("intMode", 1'b1, fourthPinIntMode);
      chkB("pullupEn", 8'h00, {4'h0, pullupEn});
      rd(8'h50, 1, 8'hC0);
   endtask : t_write_read
   task automatic t_kept();
      logic [7:0] v;
      bus.start();
      ack(8'h83, 1'b1);
      bus.recvByte(1'b0, v);
      chkB("keptSel", 8'hC0, v);
      bus.stop();
   endtask : t_kept
   task automatic t_refused();
      bus.start();
      ack(8'h84, 1'b0);
      bus.stop();
      bus.start();
      ack(8'h01, 1'b0);
      bus.stop();
      bus.start();
      ack(8'h00, 1'b1);
      ack(8'h07, 1'b0);
      bus.stop();
      chkB("portOe", 8'h05, {4'h0, portOe});
   endtask : t_refused
   task automatic t_soft_reset();
      bus.start();
      ack(8'h00, 1'b1);
      ack(8'h06, 1'b1);
      bus.rstart();
      ack(8'h82, 1'b1);
      ack(8'h01, 1'b1);
      bus.stop();
      chkB("portOe", 8'h05, {4'h0, portOe});
      bus.start();
      ack(8'h00, 1'b1);
      ack(8'h06, 1'b1);
      ack(8'h06, 1'b0);
      bus.stop();
      chkB("portOe", 8'h05, {4'h0, portOe});
      bus.start();
      ack(8'h00, 1'b1);
      ack(8'h06, 1'b1);
      bus.stop();
      bus.wt(20);
      chkB("portOe", 8'h00, {4'h0, portOe});
      chkB("portOut", 8'h0F, {4'h0, portOut});
      chk1("intMode", 1'b0, fourthPinIntMode);
      rd(8'h03, 1, 8'hFF);
   endtask : t_soft_reset
   // Cuts a hang short.
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fails++;
         test_done();
      end
   end
   // Reset, then the scenarios in order.
   initial begin
      nrst = 1'b0;
      portIn = 4'h6;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (20) @(posedge clk);
      t_defaults();
      t_write_read();
      t_kept();
      t_refused();
      t_soft_reset();
      test_done();
   end
endmodule : i2c_target_register_access_tb_top
`default_nettype wire

// *** verif/ioexp_target_props.sv ***
// Port checker for the I/O expander target engine.
// Assumes it is bound to ioexp_target and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ioexp_target_props (
   input wire logic       clk,
   input wire logic       nrst,
   input wire logic       busSampleClk,
   input wire logic       sclIn,
   input wire logic       sdaOut,
   input wire logic       sdaOe,
   input wire logic [3:0] portOut,
   input wire logic [3:0] portOe,
   input wire logic [3:0] pullupEn,
   input wire logic       fourthPinIntMode
);
   // Link side: SDA is only ever pulled low, and only moves while SCL is low.
   a_sda_out_zero: assert property (@(posedge busSampleClk) disable iff (!nrst)
      sdaOut == 1'b0) else $error("sdaOut driven high");
   a_oe_rise_low: assert property (@(posedge busSampleClk) disable iff (!nrst)
      $rose(sdaOe) |-> !sclIn) else $error("SDA pulled while SCL high");
   a_oe_hold_high: assert property (@(posedge busSampleClk) disable iff (!nrst)
      sclIn && $past(sclIn) |-> $stable(sdaOe)) else $error("SDA moved in SCL high");
   a_ack_min_width: assert property (@(posedge busSampleClk) disable iff (!nrst)
      $rose(sdaOe) |=> sdaOe [*8]) else $error("SDA pull too short");
   a_reset_link: assert property (@(posedge busSampleClk)
      !nrst [*6] |-> !sdaOe) else $error("SDA pulled in reset");
   // Core side: pull-ups follow direction and the disable bit.
   a_pull_inputs: assert property (@(posedge clk) disable iff (!nrst)
      (pullupEn & portOe) == 4'h0) else $error("pull-up on output pin");
   a_pull_uniform: assert property (@(posedge clk) disable iff (!nrst)
      pullupEn == ~portOe || pullupEn == 4'h0) else $error("pull-up mismatch");
   a_reset_core: assert property (@(posedge clk) !nrst |=> portOut == 4'hF &&
      portOe == 4'h0 && pullupEn == 4'hF && !fourthPinIntMode) else $error("bad reset");
endmodule : ioexp_target_props
bind ioexp_target ioexp_target_props u_props (.clk(clk), .nrst(nrst),
   .busSampleClk(busSampleClk), .sclIn(sclIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
   .portOut(portOut), .portOe(portOe), .pullupEn(pullupEn),
   .fourthPinIntMode(fourthPinIntMode));
`default_nettype wire
